// >>> design/isa_bus_defs.svh
// Timing counts and encodings for the ISA bus control block.
// Assumes inclusion by bare name; definitions only.
`ifndef ISA_BUS_DEFS_SVH
`define ISA_BUS_DEFS_SVH
`define CLK_PERIOD_NS      40
`define LATCH_TIME_NS      80
`define LATCH_CYCLES       ((`LATCH_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STROBE_TIME_NS     160
`define STROBE_CYCLES      ((`STROBE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DMA_CHANNELS       7
`define ACK_OUTPUTS        2
`define CHAN_SEL_W         3
`define ADDR_W             26
`define DIR_TOWARD_DEVICE  1'b1
`define DIR_OUTWARD        1'b0
`endif

// >>> design/isa_bus_pkg.sv
// Types shared by the ISA bus control modules.
// Assumes the defs header is compiled alongside.
package isa_bus_pkg;
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_LATCH = 3'b001,
      ST_CMD   = 3'b010,
      ST_WAIT  = 3'b011,
      ST_END   = 3'b100
   } cycle_state_t;
   typedef enum logic [1:0] {
      KIND_IO  = 2'b00,
      KIND_MEM = 2'b01,
      KIND_DMA = 2'b10
   } cycle_kind_t;
endpackage

// >>> design/dma_ack_if.sv
// Carries the DMA acknowledge request from the sequencer to the mapper.
// Assumes both ends share ref_clk.
`timescale 1ns/100ps
`include "isa_bus_defs.svh"
interface dma_ack_if;
   logic                      ackActive;
   logic [`CHAN_SEL_W-1:0]    activeChan;
   logic [`ACK_OUTPUTS-1:0]   ackN;
   modport seq (output ackActive, output activeChan, input ackN);
   modport map (input ackActive, input activeChan, output ackN);
endinterface

// >>> design/dma_ack_map.sv
// Maps each programmable acknowledge output to one DMA channel.
// Assumes channel maps are stable while a DMA cycle runs.
`timescale 1ns/100ps
`include "isa_bus_defs.svh"
module dma_ack_map #(
   parameter int ACKS = `ACK_OUTPUTS
) (
   // Clock and reset
   input  wire logic                        ref_clk,
   input  wire logic                        nrst,
   // Channel selection per output
   input  wire logic [ACKS*`CHAN_SEL_W-1:0] ackChanMap,
   // Sequencer side
   dma_ack_if.map                           ackBus
);
   genvar g;
   generate
      for (g = 0; g < ACKS; g++) begin : gAck
         logic ackN_r;
         always_ff @(posedge ref_clk) begin
            if (!nrst) begin
               ackN_r <= 1'b1;
            end else begin
               // Active low toward the initiator of the mapped channel.
               ackN_r <= !(ackBus.ackActive &&
                  (ackChanMap[g*`CHAN_SEL_W +: `CHAN_SEL_W] == ackBus.activeChan));
            end
         end
         assign ackBus.ackN[g] = ackN_r;
         mapped_ack_a: assert property (@(posedge ref_clk) disable iff (!nrst)
            !ackBus.ackActive |=> ackBus.ackN[g])
            else $error("acknowledge low without DMA cycle");
      end
   endgenerate
endmodule

// >>> design/isa_bus_control.sv
// ISA bus cycle sequencer: latch strobe, address enable, commands, transceiver control.
// Assumes requests from the core are synchronous to ref_clk and held until done.
`timescale 1ns/100ps
`include "isa_bus_defs.svh"
module isa_bus_control #(
   parameter int LATCH_CYC  = `LATCH_CYCLES,
   parameter int STROBE_CYC = `STROBE_CYCLES,
   parameter int ACKS       = `ACK_OUTPUTS
) (
   // Clock and reset
   input  wire logic                        ref_clk,
   input  wire logic                        nrst,
   // Core cycle request
   input  wire logic                        cycReq,
   input  wire logic [1:0]                  cycKind,
   input  wire logic                        cycWrite,
   input  wire logic                        cycCard,
   input  wire logic                        cycInternal,
   input  wire logic [`ADDR_W-1:0]          cycAddr,
   input  wire logic [`CHAN_SEL_W-1:0]      cycChan,
   output logic                             cycDone,
   output logic                             cycWide,
   // Mode straps
   input  wire logic                        localBusMode,
   input  wire logic                        wideDramMode,
   input  wire logic [ACKS*`CHAN_SEL_W-1:0] ackChanMap,
   // ISA bus
   output logic [`ADDR_W-1:0]               system_addr_bus,
   output logic                             addrLatchEn,
   output logic                             dmaAddrEn,
   output logic                             ioReadN,
   output logic                             ioWriteN,
   output logic [ACKS-1:0]                  prog_dma_ack,
   input  wire logic                        chanReady,
   input  wire logic                        ioSel16N,
   input  wire logic                        memSel16N,
   // External transceiver
   output logic                             xcvr_output_enable,
   output logic                             xcvr_dir_high_byte,
   output logic                             xcvr_dir_low_byte
);
   isa_bus_pkg::cycle_state_t state_r;
   isa_bus_pkg::cycle_kind_t  kind_r;
   logic [7:0]                count_r;
   logic                      write_r;
   logic                      card_r;
   logic                      wide_r;
   logic                      internal_r;
   logic [`CHAN_SEL_W-1:0]    chan_r;
   logic                      dataPhase;
   logic                      xcvrMode;

   dma_ack_if ackBus ();

   assign dataPhase = (state_r == isa_bus_pkg::ST_CMD) || (state_r == isa_bus_pkg::ST_WAIT);
   assign xcvrMode  = localBusMode || wideDramMode;

   // Cycle sequencer.
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         state_r    <= isa_bus_pkg::ST_IDLE;
         count_r    <= 8'h00;
         kind_r     <= isa_bus_pkg::KIND_IO;
         write_r    <= 1'b0;
         card_r     <= 1'b0;
         internal_r <= 1'b0;
         chan_r     <= '0;
         system_addr_bus <= '0;
      end else begin
         case (state_r)
            isa_bus_pkg::ST_IDLE: begin
               if (cycReq) begin
                  state_r    <= isa_bus_pkg::ST_LATCH;
                  count_r    <= 8'(LATCH_CYC);
                  kind_r     <= isa_bus_pkg::cycle_kind_t'(cycKind);
                  write_r    <= cycWrite;
                  card_r     <= cycCard;
                  // Only a DMA cycle can run entirely inside the chip.
                  internal_r <= cycInternal && (cycKind == isa_bus_pkg::KIND_DMA);
                  chan_r     <= cycChan;
                  system_addr_bus <= cycAddr;
               end
            end
            isa_bus_pkg::ST_LATCH: begin
               if (count_r == 8'h01) begin
                  state_r <= isa_bus_pkg::ST_CMD;
                  count_r <= 8'(STROBE_CYC);
               end else begin
                  count_r <= count_r - 8'h01;
               end
            end
            isa_bus_pkg::ST_CMD: begin
               if (count_r == 8'h01) begin
                  state_r <= isa_bus_pkg::ST_WAIT;
               end else begin
                  count_r <= count_r - 8'h01;
               end
            end
            isa_bus_pkg::ST_WAIT: begin
               // Internal DMA never waits on the external ready line.
               if (chanReady || internal_r) begin
                  state_r <= isa_bus_pkg::ST_END;
               end
            end
            isa_bus_pkg::ST_END: begin
               state_r <= isa_bus_pkg::ST_IDLE;
            end
            default: begin
               state_r <= isa_bus_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Latch strobe: one pulse per cycle, including card and DMA cycles.
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         addrLatchEn <= 1'b0;
      end else begin
         addrLatchEn <= (state_r == isa_bus_pkg::ST_IDLE) && cycReq;
      end
   end

   // Address enable for DMA, internal DMA and card I/O space.
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         dmaAddrEn <= 1'b0;
      end else if (state_r == isa_bus_pkg::ST_IDLE) begin
         dmaAddrEn <= cycReq && ((cycKind == isa_bus_pkg::KIND_DMA) ||
                                 (cycCard && cycKind == isa_bus_pkg::KIND_IO));
      end else if (state_r == isa_bus_pkg::ST_END) begin
         dmaAddrEn <= 1'b0;
      end
   end

   // Command strobes, I/O cycles only; card cycles keep them off the ISA side
   // only through the address enable, since the strobes are shared.
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         ioReadN  <= 1'b1;
         ioWriteN <= 1'b1;
      end else begin
         ioReadN  <= !(dataPhase && kind_r == isa_bus_pkg::KIND_IO && !write_r &&
                       !(state_r == isa_bus_pkg::ST_WAIT && (chanReady || internal_r)));
         ioWriteN <= !(dataPhase && kind_r == isa_bus_pkg::KIND_IO && write_r &&
                       !(state_r == isa_bus_pkg::ST_WAIT && (chanReady || internal_r)));
      end
   end

   // Transfer sizing is sampled at the end of the latch phase.
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         wide_r <= 1'b0;
      end else if (state_r == isa_bus_pkg::ST_LATCH && count_r == 8'h01) begin
         wide_r <= (kind_r == isa_bus_pkg::KIND_IO)  ? !ioSel16N :
                   (kind_r == isa_bus_pkg::KIND_MEM) ? !memSel16N : 1'b0;
      end
   end

   // Transceiver control; direction parks outward when idle.
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         xcvr_output_enable <= 1'b1;
         xcvr_dir_high_byte <= `DIR_OUTWARD;
         xcvr_dir_low_byte  <= `DIR_OUTWARD;
      end else begin
         xcvr_output_enable <= !(xcvrMode && dataPhase);
         xcvr_dir_high_byte <= (dataPhase && !write_r) ? `DIR_TOWARD_DEVICE
                                                       : `DIR_OUTWARD;
         xcvr_dir_low_byte  <= (dataPhase && !write_r) ? `DIR_TOWARD_DEVICE
                                                       : `DIR_OUTWARD;
      end
   end

   assign cycDone = (state_r == isa_bus_pkg::ST_END);
   assign cycWide = wide_r;

   // Acknowledge selects the I/O side of the DMA transfer.
   assign ackBus.ackActive  = dataPhase && kind_r == isa_bus_pkg::KIND_DMA && !internal_r;
   assign ackBus.activeChan = chan_r;
   assign prog_dma_ack      = ackBus.ackN;

   dma_ack_map #(.ACKS(ACKS)) uAckMap (
      .ref_clk    (ref_clk),
      .nrst       (nrst),
      .ackChanMap (ackChanMap),
      .ackBus     (ackBus)
   );

   dma_aen_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      (dataPhase && kind_r == isa_bus_pkg::KIND_DMA) |-> dmaAddrEn)
      else $error("address enable low during DMA");
   card_aen_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      (dataPhase && card_r && kind_r == isa_bus_pkg::KIND_IO) |-> dmaAddrEn)
      else $error("address enable low during card I/O");
   latch_pulse_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      (state_r == isa_bus_pkg::ST_IDLE && cycReq) |=> addrLatchEn ##1 !addrLatchEn)
      else $error("latch strobe not a one-cycle pulse");
   wait_hold_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      (state_r == isa_bus_pkg::ST_WAIT && !chanReady && !internal_r) |=>
         state_r == isa_bus_pkg::ST_WAIT)
      else $error("cycle ended while channel not ready");
   read_strobe_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      !ioReadN |-> $past(dataPhase) && !write_r && kind_r == isa_bus_pkg::KIND_IO)
      else $error("read strobe outside I/O read");
   write_strobe_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      !ioWriteN |-> $past(dataPhase) && write_r)
      else $error("write strobe outside I/O write");
   xcvr_window_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      !xcvr_output_enable |-> $past(dataPhase) && $past(xcvrMode))
      else $error("transceiver enabled outside data phase");
   read_dir_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      (dataPhase && !write_r) |=> xcvr_dir_high_byte == `DIR_TOWARD_DEVICE &&
                                  xcvr_dir_low_byte == `DIR_TOWARD_DEVICE)
      else $error("transceiver direction wrong on read");
   io_size_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      (state_r == isa_bus_pkg::ST_LATCH && count_r == 8'h01 &&
       kind_r == isa_bus_pkg::KIND_IO) |=> wide_r == !$past(ioSel16N))
      else $error("I/O transfer size not taken from select");
endmodule

// >>> testbench/isa_target_model.sv
// Behavioural ISA peripheral standing on the far side of the bus control block.
// Assumes it samples the controller's bus outputs on ref_clk.
`timescale 1ns/100ps
module isa_target_model (
   // Clock and reset
   input  wire logic       ref_clk,
   input  wire logic       nrst,
   // Bus from controller
   input  wire logic       addrLatchEn,
   input  wire logic       dmaAddrEn,
   input  wire logic       ioReadN,
   input  wire logic       ioWriteN,
   input  wire logic [1:0] prog_dma_ack,
   // Bench control
   input  wire logic [7:0] waitLen,
   input  wire logic       wideIo,
   input  wire logic       wideMem,
   // Target replies
   output logic            chanReady,
   output logic            ioSel16N,
   output logic            memSel16N,
   output int              rdSeen,
   output int              wrSeen
);
   logic [7:0] holdCnt_r;
   logic       dmaSel_r;
   logic       rdPrev_r;
   logic       wrPrev_r;
   // The ready line has a pull-up, so once released it reads high.
   assign chanReady = (holdCnt_r == 8'h00);
   // An I/O target keeps its decode off while the address enable is high.
   assign ioSel16N  = !(wideIo && !dmaAddrEn);
   assign memSel16N = !wideMem;
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         holdCnt_r <= 8'h00;
         dmaSel_r  <= 1'b0;
         rdPrev_r  <= 1'b1;
         wrPrev_r  <= 1'b1;
         rdSeen    <= 0;
         wrSeen    <= 0;
      end else begin
         rdPrev_r <= ioReadN;
         wrPrev_r <= ioWriteN;
         dmaSel_r <= dmaAddrEn && (dmaSel_r || prog_dma_ack != 2'h3);
         if (addrLatchEn && !dmaAddrEn) begin
            holdCnt_r <= waitLen;
         end else if (dmaAddrEn && prog_dma_ack != 2'h3 && !dmaSel_r) begin
            holdCnt_r <= waitLen;
         end else if (holdCnt_r != 8'h00) begin
            holdCnt_r <= holdCnt_r - 8'h01;
         end
         if (rdPrev_r && !ioReadN && !dmaAddrEn) begin
            rdSeen <= rdSeen + 1;
         end
         if (wrPrev_r && !ioWriteN && !dmaAddrEn) begin
            wrSeen <= wrSeen + 1;
         end
      end
   end
endmodule

// >>> testbench/testbench.sv
// Self-checking bench for the ISA bus control sequencer.
// Assumes the design defaults of 2 latch and 4 strobe cycles.
`timescale 1ns/100ps
`include "isa_bus_defs.svh"
module testbench;
   logic ref_clk, nrst, cycReq, cycWrite, cycCard, cycInternal, cycDone, cycWide;
   logic localBusMode, wideDramMode, addrLatchEn, dmaAddrEn, ioReadN, ioWriteN;
   logic chanReady, ioSel16N, memSel16N, wideIo, wideMem;
   logic xcvr_output_enable, xcvr_dir_high_byte, xcvr_dir_low_byte;
   logic [1:0]  cycKind, prog_dma_ack;
   logic [2:0]  cycChan;
   logic [5:0]  ackChanMap;
   logic [7:0]  waitLen, seed;
   logic [25:0] cycAddr, system_addr_bus;
   int          rdSeen, wrSeen, bad_count, checks_done;
   isa_bus_control #(.LATCH_CYC(2), .STROBE_CYC(4), .ACKS(2)) DUT (.ref_clk(ref_clk),
      .nrst(nrst), .cycReq(cycReq), .cycKind(cycKind), .cycWrite(cycWrite),
      .cycCard(cycCard), .cycInternal(cycInternal), .cycAddr(cycAddr), .cycChan(cycChan),
      .cycDone(cycDone), .cycWide(cycWide), .localBusMode(localBusMode),
      .wideDramMode(wideDramMode), .ackChanMap(ackChanMap),
      .system_addr_bus(system_addr_bus), .addrLatchEn(addrLatchEn), .dmaAddrEn(dmaAddrEn),
      .ioReadN(ioReadN), .ioWriteN(ioWriteN), .prog_dma_ack(prog_dma_ack),
      .chanReady(chanReady), .ioSel16N(ioSel16N), .memSel16N(memSel16N),
      .xcvr_output_enable(xcvr_output_enable), .xcvr_dir_high_byte(xcvr_dir_high_byte),
      .xcvr_dir_low_byte(xcvr_dir_low_byte));
   isa_target_model target (.ref_clk(ref_clk), .nrst(nrst), .addrLatchEn(addrLatchEn),
      .dmaAddrEn(dmaAddrEn), .ioReadN(ioReadN), .ioWriteN(ioWriteN),
      .prog_dma_ack(prog_dma_ack), .waitLen(waitLen), .wideIo(wideIo), .wideMem(wideMem),
      .chanReady(chanReady), .ioSel16N(ioSel16N), .memSel16N(memSel16N),
      .rdSeen(rdSeen), .wrSeen(wrSeen));
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   function automatic logic [1:0] ack_mask(input logic [5:0] m, input logic [2:0] ch);
      return {m[5:3] == ch, m[2:0] == ch};
   endfunction
   task automatic check(input logic ok, input string msg);
      checks_done++;
      if (ok !== 1'b1) begin
         bad_count++;
         $display("[FAIL] %0t %s", $time, msg);
      end
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // A cycle starts at the next edge; n counts edges from that one until done shows.
   task automatic run_cycle(input logic [1:0] k, input logic w, c, i, input logic [2:0] ch,
                            input logic [7:0] wl);
      int n, latches, rd0, wr0, base, lead;
      logic aenAll, aenAny, rdLow, wrLow, isIo, aenExp, oeExp, dirExp, expWide, hold;
      logic [1:0] ackLow;
      seed = lfsr(seed);
      isIo = (k == 2'b00);
      aenExp = (k == 2'b10) || (isIo && c);
      {latches, aenAll, aenAny, rdLow, wrLow, ackLow} = {32'd0, 1'b1, 5'h00};
      rd0 = rdSeen;
      wr0 = wrSeen;
      base = 8;
      cycKind = k; cycWrite = w; cycCard = c; cycInternal = i; cycChan = ch; waitLen = wl;
      {wideIo, wideMem, localBusMode, wideDramMode} = seed[7:4];
      cycAddr = {seed, seed ^ 8'h5a, seed, seed[1:0]};
      oeExp = !(localBusMode || wideDramMode);
      dirExp = w ? `DIR_OUTWARD : `DIR_TOWARD_DEVICE;
      cycReq = 1'b1;
      for (n = 1; n < 60; n++) begin
         @(posedge ref_clk);
         #1;
         if (addrLatchEn === 1'b1) begin
            latches++;
            check(system_addr_bus === cycAddr, "address at latch");
         end
         aenAll &= (dmaAddrEn === 1'b1);
         aenAny |= (dmaAddrEn !== 1'b0);
         rdLow |= (ioReadN !== 1'b1);
         wrLow |= (ioWriteN !== 1'b1);
         ackLow |= ~prog_dma_ack;
         if (isIo && (ioReadN === 1'b0 || ioWriteN === 1'b0)) begin
            check(xcvr_output_enable === oeExp, "transceiver enable");
            check(xcvr_dir_high_byte === dirExp, "high byte direction");
            check(xcvr_dir_low_byte === dirExp, "low byte direction");
         end
         if (cycDone === 1'b1) break;
      end
      cycReq = 1'b0;
      check(n < 60, "cycle never completed");
      if (n >= 60) wrap_up();
      expWide = isIo ? (wideIo && !c) : (k == 2'b01) ? wideMem : 1'b0;
      // The model starts holding ready low one edge after it sees the latch strobe (ISA)
      // or its acknowledge (DMA); only a hold longer than that lead stretches the cycle.
      lead = (k == 2'b10) ? 2 : 5;
      hold = (k == 2'b10) ? (!i && ack_mask(ackChanMap, ch) != 2'h0) : !aenExp;
      check(latches == 1, "latch pulse count");
      check(aenExp ? aenAll : !aenAny, "address enable");
      check(ackLow === ((k == 2'b10 && !i) ? ack_mask(ackChanMap, ch) : 2'h0), "acks");
      check(cycWide === expWide, "transfer width");
      if (isIo) check(rdLow === !w && wrLow === w, "io strobes");
      if (k == 2'b01) check(!rdLow && !wrLow, "no io strobe on memory");
      check((rdSeen - rd0) == (isIo && !c && !w), "target read count");
      check((wrSeen - wr0) == (isIo && !c && w), "target write count");
      if (!hold || wl <= lead) check(n == base, "latency");
      else check(n == base + wl - lead, "wait latency");
      @(posedge ref_clk);
      #1;
      check({xcvr_output_enable, xcvr_dir_high_byte, xcvr_dir_low_byte, dmaAddrEn} === 4'h8,
            "idle state");
      $display("cycle kind %0d write %0d card %0d internal %0d done", k, w, c, i);
   endtask
   initial begin
      {nrst, cycReq, cycKind, cycWrite, cycCard, cycInternal, cycChan} = 10'h000;
      {localBusMode, wideDramMode, wideIo, wideMem, cycAddr} = 30'h0;
      {waitLen, bad_count, checks_done} = 72'h0;
      ackChanMap = {3'h3, 3'h1};
      seed = 8'd29;
      repeat (4) @(posedge ref_clk);
      #1;
      check({addrLatchEn, dmaAddrEn, ioReadN, ioWriteN, prog_dma_ack, xcvr_output_enable,
             xcvr_dir_high_byte, xcvr_dir_low_byte, cycDone} === 10'h0f8, "reset values");
      nrst = 1'b1;
      run_cycle(2'b00, 1'b0, 1'b0, 1'b0, 3'h0, 8'h00);
      run_cycle(2'b00, 1'b1, 1'b0, 1'b0, 3'h0, 8'h0c);
      run_cycle(2'b00, 1'b0, 1'b1, 1'b0, 3'h0, 8'h09);
      run_cycle(2'b10, 1'b0, 1'b0, 1'b0, 3'h1, 8'h06);
      run_cycle(2'b10, 1'b1, 1'b0, 1'b0, 3'h3, 8'h00);
      run_cycle(2'b10, 1'b0, 1'b0, 1'b1, 3'h1, 8'h09);
      run_cycle(2'b01, 1'b1, 1'b0, 1'b0, 3'h0, 8'h05);
      // Reset in the middle of a stretched I/O read must drop every strobe within two edges.
      {cycKind, cycWrite, cycCard, cycInternal, waitLen} = 13'h000c;
      cycReq = 1'b1;
      repeat (5) @(posedge ref_clk);
      #1;
      check(ioReadN === 1'b0, "read strobe before reset");
      {nrst, cycReq} = 2'b00;
      repeat (2) @(posedge ref_clk);
      #1;
      check({addrLatchEn, dmaAddrEn, ioReadN, ioWriteN, prog_dma_ack, xcvr_output_enable,
             xcvr_dir_high_byte, xcvr_dir_low_byte, cycDone} === 10'h0f8, "mid-cycle reset");
      nrst = 1'b1;
      $display("mid-cycle reset done");
      repeat (30) begin
         seed = lfsr(seed);
         ackChanMap = {seed[2:0], seed[6:4]};
         run_cycle(2'(seed % 3), seed[3], seed[4], seed[5], 3'(seed % 7),
                   8'({6'h00, seed[7:6]} * 3));
      end
      wrap_up();
   end
endmodule
